//--- rtl/gcsc_serial_ctrl.sv
// serial gain and current control port with mode decode
// Behaviour
// - the word is eight bits MSB first, bits 7:6 current level, 5:0 gain.
// - level 11 is highest, 00 lowest, 10 and 01 in between.
// - gain codes 01 to 3c step one dB each, 01 minimum, 3c maximum.
// - a load starts when load_window_n goes low; only then clocks shift.
// - with the window open each rising serial clock samples a data bit.
// - the rising edge of load_window_n applies the shifted word.
// - the port is receive only on three lines with no readback.
// - transmit_on low mutes the amplifier between bursts, impedance kept.
// - power-down low puts the amplifier to sleep, high restores it.
// - with the window closed shifting stops and the settings hold.
// - the shifter is master-slave: rise captures, fall passes to slave.
`default_nettype none
module gcsc_serial_ctrl
  import gcsc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       serialClk,
  input  wire logic       load_window_n,
  input  wire logic       serial_word_in,
  input  wire logic       transmit_on,
  input  wire logic       power_up_n_sleep,
  output logic [1:0]      output_current_level,
  output logic [5:0]      coarse_gain,
  output logic            gainValid,
  output logic            gainInRange,
  output logic            ampEnable,
  output logic            ampAwake,
  output logic [1:0]      ampMode
);
  // field layout must tile the word exactly
  if (LEVEL_MSB != WORD_BITS - 1) begin : g_bad_level
    $error("gcsc_serial_ctrl level field must sit at the top");
  end
  if (LEVEL_LSB != GAIN_MSB + 1) begin : g_bad_split
    $error("gcsc_serial_ctrl level and gain fields must meet");
  end
  if (GAIN_LSB != 0) begin : g_bad_gain
    $error("gcsc_serial_ctrl gain field must start at bit zero");
  end
  // ports are fixed at two level bits and six gain bits
  if (WORD_BITS != 8) begin : g_bad_width
    $error("gcsc_serial_ctrl ports assume an eight-bit word");
  end
  if (GAIN_CODE_MIN > GAIN_CODE_MAX) begin : g_bad_codes
    $error("gcsc_serial_ctrl gain code bounds are reversed");
  end

  // link domain: master stage on rising serial clock
  logic [WORD_BITS-1:0] master_r;
  logic [WORD_BITS-1:0] master_nxt;
  // slave stage on falling serial clock
  logic [WORD_BITS-1:0] slave_r;
  logic [WORD_BITS-1:0] slave_nxt;
  // bit offered to each master stage
  wire  [WORD_BITS-1:0] shiftIn;
  // word latched on the closing edge of the load window
  logic [WORD_BITS-1:0] linkWord_r;
  logic [WORD_BITS-1:0] linkWord_nxt;
  logic                 loadTgl_r;
  logic                 loadTgl_nxt;

  // msb first, oldest bit drops off
  assign shiftIn[0] = serial_word_in;
  for (genvar b = 1; b < WORD_BITS; b++) begin : g_chain
    assign shiftIn[b] = slave_r[b - 1];
  end

  always_comb begin
    master_nxt = master_r;
    if (!load_window_n) begin
      master_nxt = shiftIn;
    end
  end

  // serial clock may stand still, so rst_n loads WORD_RST asynchronously
  always_ff @(posedge serialClk or negedge rst_n) begin
    if (!rst_n) begin
      master_r <= WORD_RST;
    end else begin
      master_r <= master_nxt;
    end
  end

  // falling edge passes master to slave
  always_comb begin
    slave_nxt = load_window_n ? slave_r : master_r;
  end

  always_ff @(negedge serialClk or negedge rst_n) begin
    if (!rst_n) begin
      slave_r <= WORD_RST;
    end else begin
      slave_r <= slave_nxt;
    end
  end

  // rising load window transfers the word; toggle marks the event
  always_comb begin
    linkWord_nxt = slave_r;
    loadTgl_nxt  = ~loadTgl_r;
  end

  always_ff @(posedge load_window_n or negedge rst_n) begin
    if (!rst_n) begin
      linkWord_r <= WORD_RST;
      loadTgl_r  <= 1'b0;
    end else begin
      linkWord_r <= linkWord_nxt;
      loadTgl_r  <= loadTgl_nxt;
    end
  end

  // crossings into mclk: toggle and the two async control levels
  logic [2:0] syncd;
  gcsc_sync #(
    .WIDTH (3)
  ) u_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .asyncIn ({loadTgl_r, transmit_on, power_up_n_sleep}),
    .syncOut (syncd)
  );

  logic tglSync;
  logic txOnSync;
  logic awakeSync;

  // named views of the synchronised bundle
  assign tglSync   = syncd[2];
  assign txOnSync  = syncd[1];
  assign awakeSync = syncd[0];

  // load capture group
  logic                 tglSeen_r;
  logic                 tglSeen_nxt;
  logic [WORD_BITS-1:0] word_r;
  logic [WORD_BITS-1:0] word_nxt;
  logic                 valid_r;
  logic                 valid_nxt;
  logic                 loadEvt;

  // range flag group
  logic                 inRange_r;
  logic                 inRange_nxt;

  // power state group
  logic                 enable_r;
  logic                 enable_nxt;
  logic                 awake_r;
  logic                 awake_nxt;
  gcsc_mode_t           mode_r;
  gcsc_mode_t           mode_nxt;

  always_comb begin
    loadEvt     = tglSync ^ tglSeen_r;
    tglSeen_nxt = tglSync;
    word_nxt    = word_r;
    valid_nxt   = valid_r;
    // linkWord_r settled long before the toggle lands here
    if (loadEvt) begin
      word_nxt  = linkWord_r;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tglSeen_r <= 1'b0;
      word_r    <= WORD_RST;
      valid_r   <= 1'b0;
    end else begin
      tglSeen_r <= tglSeen_nxt;
      word_r    <= word_nxt;
      valid_r   <= valid_nxt;
    end
  end

  always_comb begin
    inRange_nxt = (word_nxt[GAIN_MSB:GAIN_LSB] >= GAIN_CODE_MIN) &&
                  (word_nxt[GAIN_MSB:GAIN_LSB] <= GAIN_CODE_MAX);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      inRange_r <= 1'b0;
    end else begin
      inRange_r <= inRange_nxt;
    end
  end

  always_comb begin
    awake_nxt  = awakeSync;
    // drive gated, impedance kept
    // undefined power-up gain never reaches the output
    enable_nxt = awakeSync & txOnSync & valid_nxt;
    if (!awakeSync) begin
      mode_nxt = GCSC_SLEEP;
    end else if (!txOnSync) begin
      mode_nxt = GCSC_MUTE;
    end else begin
      mode_nxt = GCSC_RUN;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= 1'b0;
      awake_r  <= 1'b0;
      mode_r   <= GCSC_SLEEP;
    end else begin
      enable_r <= enable_nxt;
      awake_r  <= awake_nxt;
      mode_r   <= mode_nxt;
    end
  end

  // level field passes straight to the current scaler
  assign output_current_level = word_r[LEVEL_MSB:LEVEL_LSB];
  assign coarse_gain          = word_r[GAIN_MSB:GAIN_LSB];
  assign gainValid            = valid_r;
  assign gainInRange          = inRange_r;
  assign ampEnable            = enable_r;
  assign ampAwake             = awake_r;
  assign ampMode              = mode_r;
endmodule
`default_nettype wire

//--- rtl/gcsc_pkg.sv
// shared constants and types for the gain and current serial control port
`default_nettype none
package gcsc_pkg;
  localparam int unsigned WORD_BITS     = 8;
  localparam int unsigned LEVEL_MSB     = 7;
  localparam int unsigned LEVEL_LSB     = 6;
  localparam int unsigned GAIN_MSB      = 5;
  localparam int unsigned GAIN_LSB      = 0;
  localparam logic [5:0]  GAIN_CODE_MIN = 6'h01;
  localparam logic [5:0]  GAIN_CODE_MAX = 6'h3c;
  localparam logic [7:0]  WORD_RST      = 8'h00;
  localparam logic [2:0]  SYNC_RST      = 3'h0;
  localparam logic [1:0]  ACK_RST       = 2'h0;

  typedef enum logic [1:0] {
    GCSC_LVL_LOW  = 2'b00,
    GCSC_LVL_MIDL = 2'b01,
    GCSC_LVL_MIDH = 2'b10,
    GCSC_LVL_HIGH = 2'b11
  } gcsc_level_t;

  typedef enum logic [1:0] {
    GCSC_RUN  = 2'b00,
    GCSC_MUTE = 2'b01,
    GCSC_SLEEP = 2'b11
  } gcsc_mode_t;
endpackage
`default_nettype wire

//--- rtl/gcsc_sync.sv
// two-flop synchroniser for a level crossing into mclk
`default_nettype none
module gcsc_sync
  import gcsc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // refuse a width the flops cannot carry
  if (WIDTH < 1) begin : g_bad_width
    $error("gcsc_sync width must be at least one");
  end

  always_comb begin
    meta_nxt = asyncIn;
    sync_nxt = meta_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign syncOut = sync_r;
endmodule
`default_nettype wire

//--- test/gcsc_checker.sv
// output checks for the serial control port
`default_nettype none
module gcsc_checker
  import gcsc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       load_window_n,
  input wire logic       transmit_on,
  input wire logic       power_up_n_sleep,
  input wire logic [5:0] coarse_gain,
  input wire logic       gainValid,
  input wire logic       gainInRange,
  input wire logic       ampEnable,
  input wire logic       ampAwake,
  input wire logic [1:0] ampMode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sleep_mode_a: assert property (!power_up_n_sleep [*4]
    |-> ampMode == 2'b11 && !ampAwake) else $error("no sleep");
  wake_up_a: assert property (power_up_n_sleep [*4]
    |-> ampAwake) else $error("no wake");
  tx_mute_a: assert property (!transmit_on [*4]
    |-> !ampEnable) else $error("no mute");
  mute_mode_a: assert property ((power_up_n_sleep && !transmit_on) [*4]
    |-> ampMode == 2'b01) else $error("bad mute mode");
  run_mode_a: assert property (ampEnable
    |-> ampMode == 2'b00 && gainValid) else $error("bad run mode");
  // the answer lags the window edge by up to three cycles
  gain_hold_a: assert property (load_window_n [*6]
    |-> $stable(coarse_gain)) else $error("gain moved");
  range_flag_a: assert property (gainInRange ==
    (coarse_gain >= GAIN_CODE_MIN && coarse_gain <= GAIN_CODE_MAX))
    else $error("bad range flag");
  load_apply_a: assert property ($rose(load_window_n)
    |-> ##[1:5] gainValid) else $error("load not applied");
  cover property ($rose(gainValid));
  cover property (ampMode == 2'b01);
  cover property (ampEnable);
endmodule
bind gcsc_serial_ctrl gcsc_checker u_chk (.mclk, .rst_n, .load_window_n,
  .transmit_on, .power_up_n_sleep, .coarse_gain, .gainValid, .gainInRange,
  .ampEnable, .ampAwake, .ampMode);
`default_nettype wire

//--- test/gcsc_host_model.sv
// host driving the three serial control lines
`default_nettype none
module gcsc_host_model (
  output logic serialClk,
  output logic load_window_n,
  output logic serial_word_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serialClk = 1'b0;
    load_window_n = 1'b1;
    serial_word_in = 1'b0;
  end
  task automatic shift8(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      serial_word_in = w[i];
      #7.5 serialClk = 1'b1;
      #7.5 serialClk = 1'b0;
    end
  endtask
  task automatic load(input logic [7:0] a, input logic [7:0] b, input bit two);
    #3.3 load_window_n = 1'b0;
    if (two) shift8(a);
    shift8(b);
    #7.5 load_window_n = 1'b1;
    // released line must not keep a stale bit
    serial_word_in = ~serial_word_in;
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the serial control port
`default_nettype none
module tb
  import gcsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk, rst_n, transmit_on, power_up_n_sleep;
  logic       serialClk, load_window_n, serial_word_in;
  logic [1:0] output_current_level, ampMode;
  logic [5:0] coarse_gain;
  logic       gainValid, gainInRange, ampEnable, ampAwake;
  int         failures = 0, n_checks = 0, cycles = 0;
  logic [5:0] codes [4] = '{6'h01, 6'h3c, 6'h00, 6'h3f};
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  gcsc_host_model host (.serialClk, .load_window_n, .serial_word_in);
  gcsc_serial_ctrl DUT (.mclk, .rst_n, .serialClk, .load_window_n,
    .serial_word_in, .transmit_on, .power_up_n_sleep, .output_current_level,
    .coarse_gain, .gainValid, .gainInRange, .ampEnable, .ampAwake, .ampMode);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 1'b0;
    transmit_on = 1'b0;
    power_up_n_sleep = 1'b1;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({ampEnable, gainValid}, 2'b00);
    for (int i = 0; i < 4; i++) begin
      host.load(8'h00, {i[1:0], codes[i]}, 1'b0);
      repeat (6) @(posedge mclk);
      chk({output_current_level, coarse_gain}, {i[1:0], codes[i]});
      chk(gainInRange, codes[i] >= 6'h01 && codes[i] <= 6'h3c);
      $display("load %0d done", i);
    end
    host.load(8'h5a, 8'hc7, 1'b1);
    repeat (6) @(posedge mclk);
    chk({output_current_level, coarse_gain}, 8'hc7);
    transmit_on <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({ampMode, ampEnable}, 3'b001);
    transmit_on <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({ampMode, ampEnable}, 3'b010);
    power_up_n_sleep <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({ampMode, ampAwake}, 3'b110);
    $display("modes done");
    report_and_stop();
  end
endmodule
`default_nettype wire
